// >>> hdl/isb_pkg.sv
package isb_pkg;

    // ----------------------------------------
    // Widths and limits
    // ----------------------------------------
    localparam int DATA_W = 32;
    localparam int PC_W = 8;
    localparam int VAR_W = 4;
    localparam int GEN_INPUTS = 9;
    localparam int NEST_DEPTH = 8;
    localparam int SP_W = 4;
    // Largest constant magnitude accepted in a comparison
    localparam logic signed [DATA_W-1:0] MAX_NUMBER = 32'sh7FFFFFFF;
    // Variable index that reads the general input status word
    localparam logic [VAR_W-1:0] VAR_GEN_STATUS = 4'h0;
    localparam logic [SP_W-1:0] SP_FULL = 4'h8;
    localparam logic [PC_W-1:0] PC_RESET = 8'h00;
    localparam logic [GEN_INPUTS-1:0] STATUS_RESET = 9'h000;

    // ----------------------------------------
    // Statement encoding
    // ----------------------------------------
    typedef enum logic [3:0] {
        OP_OTHER = 4'h0,
        OP_IF = 4'h1,
        OP_ELSE = 4'h2,
        OP_BLOCK_END = 4'h3,
        OP_WHILE = 4'h4,
        OP_LOOP_END = 4'h5,
        OP_LOOP_EXIT = 4'h6,
        OP_COUNT = 4'h7,
        OP_COUNT_END = 4'h8,
        OP_COUNT_EXIT = 4'h9,
        OP_END = 4'hA
    } isb_op_e;

    // Both single and double equals sign encode as CMP_EQ
    typedef enum logic [2:0] {
        CMP_EQ = 3'h0,
        CMP_NE = 3'h1,
        CMP_LT = 3'h2,
        CMP_LE = 3'h3,
        CMP_GT = 3'h4,
        CMP_GE = 3'h5
    } isb_cmp_e;

    typedef enum logic [1:0] {
        KIND_IF = 2'h0,
        KIND_WHILE = 2'h1,
        KIND_COUNT = 2'h2
    } isb_kind_e;

    typedef enum logic [1:0] {
        SK_ELSE_OR_END = 2'h0,
        SK_BLOCK_END = 2'h1,
        SK_LOOP_END = 2'h2,
        SK_COUNT_END = 2'h3
    } isb_skip_e;

    typedef struct packed {
        logic is_var;
        logic [VAR_W-1:0] var_idx;
        logic signed [DATA_W-1:0] value;
    } isb_operand_s;

    typedef struct packed {
        isb_op_e op;
        isb_cmp_e cmp;
        isb_operand_s lhs;
        isb_operand_s rhs;
    } isb_stmt_s;

    typedef struct packed {
        logic valid;
        logic [11:0] bcd;
        logic [GEN_INPUTS-1:0] value;
    } isb_reply_s;

endpackage : isb_pkg

// >>> hdl/isb_interp.sv
`timescale 1ns/1ps
`default_nettype none
module isb_interp (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic ce_in,
    // Sequence control
    input wire logic start_in,
    input wire logic [isb_pkg::PC_W-1:0] start_pc_in,
    output logic busy_out,
    output logic done_out,
    output logic fault_out,
    output logic [isb_pkg::SP_W-1:0] depth_out,
    // Program store, read at pc_out in the same cycle
    output logic [isb_pkg::PC_W-1:0] pc_out,
    input wire isb_pkg::isb_stmt_s stmt_in,
    // Program variable reads
    output logic [isb_pkg::VAR_W-1:0] lhs_var_out,
    output logic [isb_pkg::VAR_W-1:0] rhs_var_out,
    input wire logic signed [isb_pkg::DATA_W-1:0] lhs_data_in,
    input wire logic signed [isb_pkg::DATA_W-1:0] rhs_data_in,
    // Other statements handed to the motion side
    output logic other_valid_out,
    input wire logic other_done_in,
    // General inputs and status word
    input wire logic [isb_pkg::GEN_INPUTS-1:0] gen_in_in,
    input wire logic [isb_pkg::GEN_INPUTS-1:0] sys_assign_in,
    output logic [isb_pkg::GEN_INPUTS-1:0] status_word_out,
    input wire logic query_in,
    input wire logic monitor_start_in,
    input wire logic monitor_stop_in,
    input wire logic monitor_interactive_in,
    output logic monitor_active_out,
    output isb_pkg::isb_reply_s reply_out
);
    import isb_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic compare(input isb_cmp_e c, input logic signed [DATA_W-1:0] a,
                                     input logic signed [DATA_W-1:0] b);
        logic r;
        r = 1'b0;
        case (c)
            CMP_EQ: r = (a == b);
            CMP_NE: r = (a != b);
            CMP_LT: r = (a < b);
            CMP_LE: r = (a <= b);
            CMP_GT: r = (a > b);
            CMP_GE: r = (a >= b);
            default: r = 1'b0;
        endcase
        return r;
    endfunction : compare

    function automatic logic [11:0] to_bcd(input logic [GEN_INPUTS-1:0] v);
        logic [11:0] d;
        d = 12'h000;
        for (int i = GEN_INPUTS - 1; i >= 0; i--) begin
            for (int k = 0; k < 3; k++) begin
                if (d[k*4 +: 4] > 4'h4) begin
                    d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
                end
            end
            d = {d[10:0], v[i]};
        end
        return d;
    endfunction : to_bcd

    // ----------------------------------------
    // General input status word
    // ----------------------------------------
    logic [GEN_INPUTS-1:0] pin_meta_reg, pin_sync_reg, status_reg, status_next;
    logic mon_reg, mon_next;
    isb_reply_s reply_reg, reply_next;

    // Pins are asynchronous, so two stages before use
    always_comb begin
        status_next = pin_sync_reg & ~sys_assign_in;
        mon_next = mon_reg;
        if (monitor_start_in && monitor_interactive_in) begin
            mon_next = 1'b1;
        end
        if (monitor_stop_in) begin
            mon_next = 1'b0;
        end
        reply_next.valid = query_in || (mon_reg && (status_next != status_reg));
        reply_next.value = status_next;
        reply_next.bcd = to_bcd(status_next);
    end

    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pin_meta_reg <= STATUS_RESET;
            pin_sync_reg <= STATUS_RESET;
            status_reg <= STATUS_RESET;
            mon_reg <= 1'b0;
            reply_reg <= '0;
        end else if (ce_in) begin
            pin_meta_reg <= gen_in_in;
            pin_sync_reg <= pin_meta_reg;
            status_reg <= status_next;
            mon_reg <= mon_next;
            reply_reg <= reply_next;
        end
    end

    assign status_word_out = status_reg;
    assign monitor_active_out = mon_reg;
    assign reply_out = reply_reg;

    // ----------------------------------------
    // Interpreter
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RUN = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_SKIP = 5'b01000,
        ST_FAULT = 5'b10000
    } isb_state_e;

    isb_state_e state_reg, state_next;
    logic [PC_W-1:0] pc_reg, pc_next;
    logic [SP_W-1:0] sp_reg, sp_next, skip_depth_reg, skip_depth_next;
    isb_skip_e skip_reg, skip_next;
    logic done_reg, done_next;
    // Block stack: kind, opener address, remaining count
    isb_kind_e stk_kind [NEST_DEPTH];
    logic [PC_W-1:0] stk_pc [NEST_DEPTH];
    logic signed [DATA_W-1:0] stk_cnt [NEST_DEPTH];
    logic push_en, cnt_wr_en;
    isb_kind_e push_kind;
    logic signed [DATA_W-1:0] push_cnt, cnt_wr;
    logic signed [DATA_W-1:0] lhs_val, rhs_val;
    logic cond_true, range_ok, opener, closer, top_ok, target_hit;
    isb_kind_e top_kind, closer_kind;
    logic [SP_W-1:0] top_idx;

    assign lhs_var_out = stmt_in.lhs.var_idx;
    assign rhs_var_out = stmt_in.rhs.var_idx;
    assign top_idx = sp_reg - 4'h1;

    // Operand fetch; status word is a readable variable
    always_comb begin
        lhs_val = stmt_in.lhs.value;
        rhs_val = stmt_in.rhs.value;
        if (stmt_in.lhs.is_var) begin
            lhs_val = (stmt_in.lhs.var_idx == VAR_GEN_STATUS) ? DATA_W'(status_reg) : lhs_data_in;
        end
        if (stmt_in.rhs.is_var) begin
            rhs_val = (stmt_in.rhs.var_idx == VAR_GEN_STATUS) ? DATA_W'(status_reg) : rhs_data_in;
        end
        // Constants must stay within plus/minus the maximum number
        range_ok = (stmt_in.lhs.is_var || (stmt_in.lhs.value >= -MAX_NUMBER))
                && (stmt_in.rhs.is_var || (stmt_in.rhs.value >= -MAX_NUMBER));
        cond_true = compare(stmt_in.cmp, lhs_val, rhs_val);
        opener = (stmt_in.op == OP_IF) || (stmt_in.op == OP_WHILE) || (stmt_in.op == OP_COUNT);
        closer = (stmt_in.op == OP_BLOCK_END) || (stmt_in.op == OP_LOOP_END) || (stmt_in.op == OP_COUNT_END);
        closer_kind = (stmt_in.op == OP_LOOP_END) ? KIND_WHILE :
                      (stmt_in.op == OP_COUNT_END) ? KIND_COUNT : KIND_IF;
        top_kind = stk_kind[top_idx[2:0]];
        top_ok = (sp_reg != 4'h0) && (top_kind == closer_kind);
        target_hit = ((skip_reg == SK_ELSE_OR_END || skip_reg == SK_BLOCK_END) && closer_kind == KIND_IF)
                  || (skip_reg == SK_LOOP_END && closer_kind == KIND_WHILE)
                  || (skip_reg == SK_COUNT_END && closer_kind == KIND_COUNT);
    end

    // Next-state logic; one statement per enabled cycle
    always_comb begin
        state_next = state_reg;
        pc_next = pc_reg;
        sp_next = sp_reg;
        skip_next = skip_reg;
        skip_depth_next = skip_depth_reg;
        done_next = 1'b0;
        push_en = 1'b0;
        push_kind = KIND_IF;
        push_cnt = lhs_val;
        cnt_wr_en = 1'b0;
        cnt_wr = stk_cnt[top_idx[2:0]] - 32'sh1;
        case (state_reg)
            ST_IDLE: begin
                if (start_in) begin
                    state_next = ST_RUN;
                    pc_next = start_pc_in;
                    sp_next = 4'h0;
                end
            end
            ST_RUN: begin
                pc_next = pc_reg + 8'h01;
                case (stmt_in.op)
                    OP_OTHER: begin
                        pc_next = pc_reg;
                        state_next = ST_WAIT;
                    end
                    OP_IF, OP_WHILE, OP_COUNT: begin
                        push_kind = (stmt_in.op == OP_IF) ? KIND_IF :
                                    (stmt_in.op == OP_WHILE) ? KIND_WHILE : KIND_COUNT;
                        if (sp_reg == SP_FULL || !range_ok) begin
                            state_next = ST_FAULT;
                            pc_next = pc_reg;
                        end else begin
                            push_en = 1'b1;
                            sp_next = sp_reg + 4'h1;
                            if (stmt_in.op == OP_COUNT ? (lhs_val <= 32'sh0) : !cond_true) begin
                                state_next = ST_SKIP;
                                skip_depth_next = 4'h0;
                                skip_next = (stmt_in.op == OP_IF) ? SK_ELSE_OR_END :
                                            (stmt_in.op == OP_WHILE) ? SK_LOOP_END : SK_COUNT_END;
                            end
                        end
                    end
                    OP_ELSE: begin
                        state_next = ST_SKIP;
                        skip_next = SK_BLOCK_END;
                        skip_depth_next = 4'h0;
                    end
                    OP_LOOP_EXIT, OP_COUNT_EXIT: begin
                        state_next = ST_SKIP;
                        skip_next = (stmt_in.op == OP_LOOP_EXIT) ? SK_LOOP_END : SK_COUNT_END;
                        skip_depth_next = 4'h0;
                    end
                    OP_BLOCK_END, OP_LOOP_END, OP_COUNT_END: begin
                        if (!top_ok) begin
                            state_next = ST_FAULT;
                            pc_next = pc_reg;
                        end else if (stmt_in.op == OP_LOOP_END) begin
                            sp_next = sp_reg - 4'h1;
                            pc_next = stk_pc[top_idx[2:0]];
                        end else if (stmt_in.op == OP_COUNT_END && cnt_wr > 32'sh0) begin
                            cnt_wr_en = 1'b1;
                            pc_next = stk_pc[top_idx[2:0]] + 8'h01;
                        end else begin
                            sp_next = sp_reg - 4'h1;
                        end
                    end
                    OP_END: begin
                        pc_next = pc_reg;
                        state_next = (sp_reg == 4'h0) ? ST_IDLE : ST_FAULT;
                        done_next = (sp_reg == 4'h0);
                    end
                    default: begin
                        state_next = ST_FAULT;
                        pc_next = pc_reg;
                    end
                endcase
            end
            ST_WAIT: begin
                if (other_done_in) begin
                    pc_next = pc_reg + 8'h01;
                    state_next = ST_RUN;
                end
            end
            ST_SKIP: begin
                pc_next = pc_reg + 8'h01;
                if (stmt_in.op == OP_END) begin
                    state_next = ST_FAULT;
                    pc_next = pc_reg;
                end else if (opener) begin
                    if (skip_depth_reg == SP_FULL) begin
                        state_next = ST_FAULT;
                    end
                    skip_depth_next = skip_depth_reg + 4'h1;
                end else if (closer && skip_depth_reg != 4'h0) begin
                    skip_depth_next = skip_depth_reg - 4'h1;
                end else if (closer) begin
                    // Enclosing blocks left on the way out are popped too
                    sp_next = sp_reg - 4'h1;
                    if (!top_ok) begin
                        state_next = ST_FAULT;
                    end else if (target_hit) begin
                        state_next = ST_RUN;
                    end
                end else if (stmt_in.op == OP_ELSE && skip_depth_reg == 4'h0 && skip_reg == SK_ELSE_OR_END) begin
                    state_next = ST_RUN;
                end
            end
            ST_FAULT: begin
                // Held until a new start; stack state is discarded
                if (start_in) begin
                    state_next = ST_RUN;
                    pc_next = start_pc_in;
                    sp_next = 4'h0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Interpreter registers and block stack
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            state_reg <= ST_IDLE;
            pc_reg <= PC_RESET;
            sp_reg <= 4'h0;
            skip_reg <= SK_ELSE_OR_END;
            skip_depth_reg <= 4'h0;
            done_reg <= 1'b0;
            for (int i = 0; i < NEST_DEPTH; i++) begin
                stk_kind[i] <= KIND_IF;
                stk_pc[i] <= PC_RESET;
                stk_cnt[i] <= 32'sh0;
            end
        end else if (ce_in) begin
            state_reg <= state_next;
            pc_reg <= pc_next;
            sp_reg <= sp_next;
            skip_reg <= skip_next;
            skip_depth_reg <= skip_depth_next;
            done_reg <= done_next;
            if (push_en) begin
                stk_kind[sp_reg[2:0]] <= push_kind;
                stk_pc[sp_reg[2:0]] <= pc_reg;
                stk_cnt[sp_reg[2:0]] <= push_cnt;
            end
            if (cnt_wr_en) begin
                stk_cnt[top_idx[2:0]] <= cnt_wr;
            end
        end
    end

    // Outputs
    assign pc_out = pc_reg;
    assign busy_out = (state_reg == ST_RUN) || (state_reg == ST_WAIT) || (state_reg == ST_SKIP);
    assign fault_out = (state_reg == ST_FAULT);
    assign done_out = done_reg;
    assign depth_out = sp_reg;
    assign other_valid_out = (state_reg == ST_WAIT);

endmodule : isb_interp
`default_nettype wire

// >>> verif/isb_interp_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module isb_interp_chk
    import isb_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Watched ports
    input wire logic ce_in,
    input wire logic start_in,
    input wire logic [PC_W-1:0] start_pc_in,
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic [SP_W-1:0] depth_out,
    input wire logic [PC_W-1:0] pc_out,
    input wire logic [GEN_INPUTS-1:0] gen_in_in,
    input wire logic [GEN_INPUTS-1:0] sys_assign_in,
    input wire logic [GEN_INPUTS-1:0] status_word_out,
    input wire logic query_in,
    input wire logic monitor_start_in,
    input wire logic monitor_stop_in,
    input wire logic monitor_interactive_in,
    input wire logic monitor_active_out,
    input wire isb_reply_s reply_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_depth_bound: assert property (depth_out <= SP_FULL)
        else $error("depth above eight");
    a_start_run: assert property (ce_in && start_in && !busy_out |=> busy_out && pc_out == $past(start_pc_in))
        else $error("start not taken");
    a_sys_zero: assert property ($past(ce_in) && $stable(sys_assign_in) |-> (status_word_out & sys_assign_in) == 9'h000)
        else $error("assigned input not masked");
    a_pin_weight: assert property ((ce_in && $stable(gen_in_in) && $stable(sys_assign_in)) [*5]
        |-> status_word_out == (gen_in_in & ~sys_assign_in))
        else $error("status word wrong");
    a_reply_next: assert property (ce_in && query_in |=> reply_out.valid && reply_out.value == status_word_out)
        else $error("query reply missing");
    a_reply_digits: assert property (reply_out.valid |-> {3'h0, reply_out.value} ==
        reply_out.bcd[11:8] * 12'h064 + reply_out.bcd[7:4] * 12'h00A + reply_out.bcd[3:0])
        else $error("reply digits wrong");
    a_monitor_refuse: assert property (ce_in && monitor_start_in && !monitor_interactive_in && !monitor_active_out
        |=> !monitor_active_out)
        else $error("monitor started from sequence");
    a_monitor_stop: assert property (ce_in && monitor_stop_in |=> !monitor_active_out)
        else $error("monitor not stopped");
    // Main scenarios reached
    c_done: cover property (done_out);
    c_full: cover property (depth_out == SP_FULL);
    c_reply: cover property (reply_out.valid);
endmodule : isb_interp_chk
bind isb_interp isb_interp_chk u_isb_interp_chk (.clock_in, .reset_in, .ce_in, .start_in, .start_pc_in,
    .busy_out, .done_out, .depth_out, .pc_out, .gen_in_in, .sys_assign_in, .status_word_out, .query_in,
    .monitor_start_in, .monitor_stop_in, .monitor_interactive_in, .monitor_active_out, .reply_out);
`default_nettype wire

// >>> verif/isb_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Program store, variable and motion side
// ----------------------------------------
module isb_prog_model
    import isb_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // Store and variables
    input wire logic [PC_W-1:0] pc_in,
    output isb_stmt_s stmt_out,
    input wire logic [VAR_W-1:0] lhs_var_in,
    input wire logic [VAR_W-1:0] rhs_var_in,
    output logic signed [DATA_W-1:0] lhs_data_out,
    output logic signed [DATA_W-1:0] rhs_data_out,
    // Handed-out statements
    input wire logic other_valid_in,
    output logic other_done_out
);
    isb_stmt_s mem [256];
    logic signed [DATA_W-1:0] var1 = 32'sh0;
    int log_q[$];
    int wait_cnt;
    // bench loads bracketed blocks, plus one left open to test the fault
    assign stmt_out = mem[pc_in];
    // Unused variables read a moving pattern, not zero
    assign lhs_data_out = (lhs_var_in == 4'h1) ? var1 : {24'h0, pc_in};
    assign rhs_data_out = (rhs_var_in == 4'h1) ? var1 : {24'h0, ~pc_in};
    // Completion after zero to two stalls; each one bumps var1
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in || !other_valid_in) begin
            other_done_out <= 1'b0;
            wait_cnt <= 0;
        end else if (!other_done_out && wait_cnt == log_q.size() % 3) begin
            other_done_out <= 1'b1;
            log_q.push_back(int'(pc_in));
            var1 <= var1 + 32'sh1;
        end else if (!other_done_out) begin
            wait_cnt <= wait_cnt + 1;
        end
    end
endmodule : isb_prog_model
`default_nettype wire

// >>> verif/test_isb_interp.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Interpreter bench
// ----------------------------------------
module test_isb_interp;
    import isb_pkg::*;
    logic clock_in = 1'b0;
    logic reset_in = 1'b1;
    logic ce_in = 1'b1;
    logic start_in = 1'b0;
    logic [PC_W-1:0] start_pc_in = 8'h00;
    logic query_in = 1'b0;
    logic monitor_start_in = 1'b0;
    logic monitor_stop_in = 1'b0;
    logic monitor_interactive_in = 1'b0;
    logic [GEN_INPUTS-1:0] gen_in_in = 9'h000;
    logic [GEN_INPUTS-1:0] sys_assign_in = 9'h000;
    logic busy_out, done_out, fault_out, other_valid_out, other_done_in, monitor_active_out;
    logic [SP_W-1:0] depth_out;
    logic [PC_W-1:0] pc_out;
    logic [VAR_W-1:0] lhs_var_out, rhs_var_out;
    logic signed [DATA_W-1:0] lhs_data_in, rhs_data_in;
    logic [GEN_INPUTS-1:0] status_word_out;
    isb_stmt_s stmt_in;
    isb_reply_s reply_out;
    int fail_count = 0;
    int cmp_count = 0;
    int max_depth, a, b, v;
    int exp_q[$];
    logic [31:0] seed = 32'h00000003;
    bit ce_rand = 1'b0;
    isb_interp u_isb_interp (.clock_in, .reset_in, .ce_in, .start_in, .start_pc_in, .busy_out, .done_out,
        .fault_out, .depth_out, .pc_out, .stmt_in, .lhs_var_out, .rhs_var_out, .lhs_data_in, .rhs_data_in,
        .other_valid_out, .other_done_in, .gen_in_in, .sys_assign_in, .status_word_out, .query_in,
        .monitor_start_in, .monitor_stop_in, .monitor_interactive_in, .monitor_active_out, .reply_out);
    isb_prog_model u_isb_prog_model (.clock_in, .reset_in, .pc_in(pc_out), .stmt_out(stmt_in),
        .lhs_var_in(lhs_var_out), .rhs_var_in(rhs_var_out), .lhs_data_out(lhs_data_in),
        .rhs_data_out(rhs_data_in), .other_valid_in(other_valid_out), .other_done_out(other_done_in));
    // Clock
    always #10 clock_in = ~clock_in;
    // Freeze every other cycle while enabled, to stretch timing
    always @(negedge clock_in) ce_in <= !ce_rand || !ce_in;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic bit truth(input isb_cmp_e c, input int x, input int y);
        case (c)
            CMP_EQ: return x == y;
            CMP_NE: return x != y;
            CMP_LT: return x < y;
            CMP_LE: return x <= y;
            CMP_GT: return x > y;
            default: return x >= y;
        endcase
    endfunction : truth
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    task automatic put(input int ad, input isb_op_e op, input isb_cmp_e c = CMP_EQ, input int l = 0,
                       input bit lv = 1'b0, input int r = 0);
        u_isb_prog_model.mem[ad] = '{op, c, '{lv, {3'h0, lv}, DATA_W'(l)}, '{1'b0, 4'h0, DATA_W'(r)}};
    endtask : put
    // Start at 0, wait bounded for done or fault, compare log
    task automatic run(input bit exp_fault);
        int n;
        u_isb_prog_model.log_q.delete();
        u_isb_prog_model.var1 = 0;
        max_depth = 0;
        n = 0;
        start_in = 1'b1;
        while (busy_out !== 1'b1 && n < 50) begin
            @(negedge clock_in);
            n++;
        end
        start_in = 1'b0;
        while (done_out !== 1'b1 && fault_out !== 1'b1 && n < 900) begin
            max_depth = (depth_out > max_depth) ? int'(depth_out) : max_depth;
            @(negedge clock_in);
            n++;
        end
        check("fault", fault_out, exp_fault);
        // A run that hits the limit shows neither flag; if done is expected it fails here, else at the fault check
        check("done", done_out, !exp_fault);
        check("log size", u_isb_prog_model.log_q.size(), exp_q.size());
        foreach (exp_q[i]) check("log pc", u_isb_prog_model.log_q[i], exp_q[i]);
        @(negedge clock_in);
    endtask : run
    // Watchdog, about three times the sum of all run limits
    initial begin
        #1500000;
        fail_count++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clock_in);
        @(negedge clock_in);
        reset_in = 1'b0;
        // true takes first arm, false the alternative
        put(0, OP_IF, CMP_EQ, 4, 0, 4);
        put(5, OP_IF, CMP_NE, 4, 0, 4);
        for (int i = 0; i < 4; i++) put((i < 2) ? 2 * i + 1 : 2 * i + 2, OP_OTHER);
        for (int i = 0; i < 2; i++) begin
            put(5 * i + 2, OP_ELSE);
            put(5 * i + 4, OP_BLOCK_END);
        end
        put(10, OP_END);
        exp_q = '{1, 8};
        run(1'b0);
        ce_rand = 1'b1;
        for (int k = 0; k < 24; k++) begin
            a = (k % 2) ? int'(rnd()) >>> 1 : int'(rnd() % 3) - 1;
            b = (k % 2) ? int'(rnd()) >>> 1 : int'(rnd() % 3) - 1;
            a = (k == 23) ? MAX_NUMBER : a;
            put(0, OP_IF, isb_cmp_e'(k % 6), a, 0, b);
            put(1, OP_OTHER);
            put(2, OP_BLOCK_END);
            put(3, OP_END);
            exp_q.delete();
            if (truth(isb_cmp_e'(k % 6), a, b)) exp_q.push_back(1);
            run(1'b0);
        end
        // constant beyond the maximum number faults
        put(0, OP_IF, CMP_EQ, -MAX_NUMBER - 1);
        exp_q.delete();
        run(1'b1);
        // loop repeats, exit lands past loop end; counted loop too
        for (int w = 0; w < 2; w++) begin
            put(0, w ? OP_COUNT : OP_WHILE, CMP_LT, w ? 3 : 0, !w, 3);
            put(1, OP_OTHER);
            put(2, OP_IF, CMP_EQ, 0, 1, 2);
            put(3, w ? OP_COUNT_EXIT : OP_LOOP_EXIT);
            put(4, OP_BLOCK_END);
            put(5, w ? OP_COUNT_END : OP_LOOP_END);
            put(6, OP_OTHER);
            put(7, OP_END);
            exp_q = '{1, 1, 6};
            run(1'b0);
        end
        ce_rand = 1'b0;
        // eight levels run, nine fault, open block faults
        exp_q.delete();
        for (int d = 8; d < 10; d++) begin
            for (int i = 0; i < d; i++) put(i, OP_IF, CMP_GE, 1, 0, 0);
            for (int i = 0; i < d; i++) put(d + i, OP_BLOCK_END);
            put(2 * d, OP_END);
            run(d > 8);
            check("max depth", max_depth, 8);
        end
        put(1, OP_END);
        run(1'b1);
        for (int k = 0; k < 20; k++) begin
            gen_in_in = (k == 0) ? 9'h020 : 9'(rnd());
            sys_assign_in = (k < 4) ? 9'h000 : 9'(rnd() & rnd());
            repeat (4) @(negedge clock_in);
            query_in = 1'b1;
            @(negedge clock_in);
            query_in = 1'b0;
            v = gen_in_in & ~sys_assign_in;
            check("status", status_word_out, v);
            check("value", reply_out.value, v);
            check("reply", reply_out.valid, 1);
            check("bcd", reply_out.bcd, ((v / 100) << 8) | ((v / 10 % 10) << 4) | (v % 10));
        end
        // monitor refused from sequence, taken interactively
        for (int k = 0; k < 3; k++) begin
            monitor_interactive_in = (k == 1);
            monitor_start_in = (k < 2);
            monitor_stop_in = (k == 2);
            @(negedge clock_in);
            check("monitor", monitor_active_out, k == 1);
        end
        end_of_test();
    end
endmodule : test_isb_interp
`default_nettype wire
